// ---- rtl/rac_ctrl.sv ----
// Alarm and carry control register with interrupt requests.
// Assumes a plain register port and pulse inputs from the counters.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rac_ctrl #(
    parameter int FIELDS = rac_pkg::ALARM_FIELDS,
    parameter int FW     = rac_pkg::FIELD_W
) (
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic                       manual_rst,
    input  wire logic                       standby,
    input  wire logic [rac_pkg::REG_AW-1:0] bus_addr,
    input  wire logic [rac_pkg::REG_DW-1:0] bus_wdata,
    input  wire logic                       bus_wr,
    input  wire logic                       bus_rd,
    output var  logic [rac_pkg::REG_DW-1:0] bus_rdata,
    input  wire logic [FIELDS*FW-1:0]       cmp_count,
    input  wire logic [FIELDS*FW-1:0]       cmp_alarm,
    input  wire logic [FIELDS-1:0]          cmp_enable,
    input  wire logic                       sec_carry,
    input  wire logic                       r64_carry,
    input  wire logic                       r64_reading,
    output var  logic                       alarm_irq,
    output var  logic                       carry_irq,
    output var  logic                       irq
);
    import rac_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic               alarm_match_flag;
    logic               carry_flag;
    logic               alarm_irq_enable;
    logic               carry_irq_enable;
    logic [EV_W-1:0]    irq_status;
    logic [EV_W-1:0]    irq_mask;
    logic [EV_W-1:0]    events;
    logic [REG_DW-1:0]  ctrl_value;
    logic               match_rise;
    logic               alarm_set;
    logic               carry_set;
    logic               wr_ctrl;
    logic               wr_stat;
    logic               wr_mask;

    // ------------------------------------------------------------------
    // Alarm comparison
    // ------------------------------------------------------------------
    rac_alarm_match #(
        .FIELDS (FIELDS),
        .FW     (FW)
    ) u_match (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .cmp_count  (cmp_count),
        .cmp_alarm  (cmp_alarm),
        .cmp_enable (cmp_enable),
        .match_rise (match_rise)
    );

    // ------------------------------------------------------------------
    // Decode and set conditions
    // ------------------------------------------------------------------
    // Control register writes and flag sets are held off during standby.
    assign wr_ctrl   = bus_wr && (bus_addr == CTRL_OFS) && !standby;
    assign wr_stat   = bus_wr && (bus_addr == IRQ_STAT_OFS);
    assign wr_mask   = bus_wr && (bus_addr == IRQ_MASK_OFS);
    assign alarm_set = match_rise && !standby;
    assign carry_set = (sec_carry || (r64_carry && r64_reading))
                       && !standby;

    always_comb begin
        events           = '0;
        events[EV_ALARM] = alarm_set;
        events[EV_CARRY] = carry_set;
    end

    // Reserved bits 1, 2, 5 and 6 read as zero.
    always_comb begin
        ctrl_value          = '0;
        ctrl_value[ALARM_FLAG_BIT] = alarm_match_flag;
        ctrl_value[AIE_BIT]        = alarm_irq_enable;
        ctrl_value[CIE_BIT]        = carry_irq_enable;
        ctrl_value[CARRY_FLAG_BIT] = carry_flag;
    end

    // ------------------------------------------------------------------
    // Alarm flag
    // ------------------------------------------------------------------
    // Flags get a value at power-on only to keep simulation defined.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_match_flag <= FLAG_RST;
        end else if (alarm_set) begin
            alarm_match_flag <= 1'h1;
        end else if (wr_ctrl && !bus_wdata[ALARM_FLAG_BIT]) begin
            alarm_match_flag <= 1'h0;
        end
    end

    // ------------------------------------------------------------------
    // Carry flag
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            carry_flag <= FLAG_RST;
        end else if (carry_set) begin
            carry_flag <= 1'h1;
        end else if (wr_ctrl && !bus_wdata[CARRY_FLAG_BIT]) begin
            carry_flag <= 1'h0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_irq_enable <= ENABLE_RST;
            carry_irq_enable <= ENABLE_RST;
        end else if (manual_rst) begin
            alarm_irq_enable <= ENABLE_RST;
            carry_irq_enable <= ENABLE_RST;
        end else if (wr_ctrl) begin
            alarm_irq_enable <= bus_wdata[AIE_BIT];
            carry_irq_enable <= bus_wdata[CIE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Event status and mask
    // ------------------------------------------------------------------
    // A new event wins over a clear written in the same cycle.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= STAT_RST;
        end else if (wr_stat) begin
            irq_status <= (irq_status & ~bus_wdata[EV_W-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask <= MASK_RST;
        end else if (wr_mask) begin
            irq_mask <= bus_wdata[EV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= '0;
        end else if (bus_rd) begin
            unique case (bus_addr)
                CTRL_OFS:     bus_rdata <= ctrl_value;
                IRQ_STAT_OFS: bus_rdata <= {{(REG_DW-EV_W){1'b0}},
                                            irq_status};
                IRQ_MASK_OFS: bus_rdata <= {{(REG_DW-EV_W){1'b0}},
                                            irq_mask};
                default:      bus_rdata <= '0;
            endcase
        end else begin
            bus_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_irq <= 1'h0;
            carry_irq <= 1'h0;
        end else begin
            alarm_irq <= alarm_match_flag && alarm_irq_enable;
            carry_irq <= carry_flag && carry_irq_enable;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'h0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_CTRL_READBACK: assert property (
        @(posedge clock) disable iff (sys_rst)
        (bus_rd && bus_addr == CTRL_OFS) |=> (bus_rdata == $past(ctrl_value))
    ) else $error("Control register read returned a wrong value.");

    AST_MANUAL_CLR: assert property (
        @(posedge clock) disable iff (sys_rst)
        manual_rst |=> (!alarm_irq_enable && !carry_irq_enable)
                       ##1 (!alarm_irq && !carry_irq)
    ) else $error("Manual reset did not clear the interrupt enables.");

    AST_STANDBY_HOLD: assert property (
        @(posedge clock) disable iff (sys_rst)
        (standby && !manual_rst) |=> $stable(ctrl_value)
    ) else $error("Control register changed during standby.");

    AST_ALARM_SET: assert property (
        @(posedge clock) disable iff (sys_rst)
        (match_rise && !standby) |=> alarm_match_flag
    ) else $error("Alarm flag did not set on a match.");

    AST_ALARM_W0: assert property (
        @(posedge clock) disable iff (sys_rst)
        (wr_ctrl && !bus_wdata[ALARM_FLAG_BIT] && !alarm_set)
        |=> !alarm_match_flag
    ) else $error("Writing zero did not clear the alarm flag.");

    AST_ALARM_W1: assert property (
        @(posedge clock) disable iff (sys_rst)
        (wr_ctrl && bus_wdata[ALARM_FLAG_BIT] && !alarm_set)
        |=> $stable(alarm_match_flag)
    ) else $error("Writing one changed the alarm flag.");

    AST_ALARM_IRQ: assert property (
        @(posedge clock) disable iff (sys_rst)
        alarm_irq == $past(alarm_match_flag && alarm_irq_enable)
    ) else $error("Alarm request does not follow flag and enable.");

    AST_CARRY_IRQ: assert property (
        @(posedge clock) disable iff (sys_rst)
        (carry_flag && carry_irq_enable) [*2] |-> carry_irq
    ) else $error("Carry request missing while flag and enable set.");

    AST_CARRY_SET: assert property (
        @(posedge clock) disable iff (sys_rst)
        (!standby && (sec_carry || (r64_carry && r64_reading)))
        |=> carry_flag && irq_status[EV_CARRY]
    ) else $error("Carry flag or carry event did not set.");

    AST_CARRY_W0: assert property (
        @(posedge clock) disable iff (sys_rst)
        (wr_ctrl && !bus_wdata[CARRY_FLAG_BIT] && !carry_set) |=> !carry_flag
    ) else $error("Writing zero did not clear the carry flag.");

    AST_RSVD_ZERO: assert property (
        @(posedge clock) disable iff (sys_rst)
        (bus_rd && bus_addr == CTRL_OFS)
        |=> (bus_rdata[2:1] == 2'h0) && (bus_rdata[6:5] == 2'h0)
    ) else $error("Reserved control bits did not read as zero.");

    AST_IRQ_DROP: assert property (
        @(posedge clock) disable iff (sys_rst)
        ($fell(alarm_match_flag) || $fell(alarm_irq_enable)) |=> !alarm_irq
    ) else $error("Alarm request stayed up after the clear.");

endmodule : rac_ctrl
`default_nettype wire

// ---- rtl/rac_pkg.sv ----
// Constants of the alarm and carry control register block.
// Assumes one clock and a plain register port with 8-bit data.
//
// What this block does
// - One 8-bit register holds flags and enables.
// - Both resets clear both interrupt enables.
// - Other bits need no reset value.
// - Standby leaves the register untouched, except a manual reset still clears the enables.
// - Alarm flag sets when enabled compares match.
// - Writing 0 clears alarm flag; 1 ignored.
// - Bit 3 enables the alarm interrupt.
// - Bit 4 enables the carry interrupt.
// - Carry flag sets on sec_carry, and on r64_carry only while r64_reading.
// - Writing 0 to bit 7 clears carry.
package rac_pkg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int           REG_AW       = 8;
    localparam int           REG_DW       = 8;
    localparam logic [7:0]   CTRL_OFS     = 8'h38;
    localparam logic [7:0]   IRQ_STAT_OFS = 8'h40;
    localparam logic [7:0]   IRQ_MASK_OFS = 8'h44;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int           ALARM_FLAG_BIT = 0;
    localparam int           AIE_BIT      = 3;
    localparam int           CIE_BIT      = 4;
    localparam int           CARRY_FLAG_BIT = 7;
    localparam logic         FLAG_RST     = 1'h0;
    localparam logic         ENABLE_RST   = 1'h0;

    // ------------------------------------------------------------------
    // Event status and mask
    // ------------------------------------------------------------------
    localparam int           EV_W         = 2;
    localparam int           EV_ALARM     = 0;
    localparam int           EV_CARRY     = 1;
    localparam logic [1:0]   STAT_RST     = 2'h0;
    localparam logic [1:0]   MASK_RST     = 2'h0;

    // ------------------------------------------------------------------
    // Alarm comparison
    // ------------------------------------------------------------------
    localparam int           ALARM_FIELDS = 6;
    localparam int           FIELD_W      = 8;

endpackage : rac_pkg

// ---- rtl/rac_alarm_match.sv ----
// Alarm comparator: all enabled alarm fields against their counters.
// Assumes counter and alarm values are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_match #(
    parameter int FIELDS = rac_pkg::ALARM_FIELDS,
    parameter int FW     = rac_pkg::FIELD_W
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic [FIELDS*FW-1:0] cmp_count,
    input  wire logic [FIELDS*FW-1:0] cmp_alarm,
    input  wire logic [FIELDS-1:0]    cmp_enable,
    output var  logic                 match_rise
);
    import rac_pkg::*;

    // ------------------------------------------------------------------
    // Per-field compare
    // ------------------------------------------------------------------
    logic [FIELDS-1:0] field_ok;
    logic              all_match;
    logic              match_prev;

    for (genvar i = 0; i < FIELDS; i++) begin : g_field
        assign field_ok[i] = !cmp_enable[i] ||
            (cmp_count[i*FW +: FW] == cmp_alarm[i*FW +: FW]);
    end

    // A match needs at least one field taking part.
    assign all_match = (&field_ok) && (|cmp_enable);

    // ------------------------------------------------------------------
    // Edge of the match
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            match_prev <= 1'h0;
            match_rise <= 1'h0;
        end else begin
            match_prev <= all_match;
            match_rise <= all_match && !match_prev;
        end
    end

    AST_MATCH_RISE: assert property (
        @(posedge clock) disable iff (sys_rst)
        (all_match && !match_prev) |=> match_rise
    ) else $error("Alarm match edge was not reported.");

endmodule : rac_alarm_match
`default_nettype wire

// ---- verif/test_rac_ctrl.sv ----
// Self-checking testbench for the alarm and carry control register block.
// Assumes the design drives registered read data one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module test_rac_ctrl;
    import rac_pkg::*;

    logic                 clock;
    logic                 sys_rst;
    logic                 manual_rst;
    logic                 standby;
    logic [REG_AW-1:0]    bus_addr;
    logic [REG_DW-1:0]    bus_wdata;
    logic                 bus_wr;
    logic                 bus_rd;
    logic [REG_DW-1:0]    bus_rdata;
    logic [47:0]          cmp_count;
    logic [47:0]          cmp_alarm;
    logic [5:0]           cmp_enable;
    logic                 sec_carry;
    logic                 r64_carry;
    logic                 r64_reading;
    logic                 alarm_irq;
    logic                 carry_irq;
    logic                 irq;
    int                   num_errors;
    int                   check_count;

    rac_ctrl i_dut (
        .clock(clock), .sys_rst(sys_rst), .manual_rst(manual_rst),
        .standby(standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .cmp_count(cmp_count), .cmp_alarm(cmp_alarm),
        .cmp_enable(cmp_enable), .sec_carry(sec_carry),
        .r64_carry(r64_carry), .r64_reading(r64_reading),
        .alarm_irq(alarm_irq), .carry_irq(carry_irq), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Clock and common tasks
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clock);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clock);
        bus_rd   <= 1'b0;
        #1;
        chk("read data", bus_rdata, exp);
    endtask : rd

    task automatic sec_pulse;
        @(posedge clock);
        sec_carry <= 1'b1;
        @(posedge clock);
        sec_carry <= 1'b0;
    endtask : sec_pulse

    task automatic r64_pulse;
        @(posedge clock);
        r64_carry <= 1'b1;
        @(posedge clock);
        r64_carry <= 1'b0;
    endtask : r64_pulse

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        num_errors = 0;
        check_count = 0;
        sys_rst = 1'b1;
        manual_rst = 1'b0;
        standby = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        cmp_count = 48'h0;
        cmp_alarm = 48'hFFFF_FFFF_FFFF;
        cmp_enable = 6'h00;
        sec_carry = 1'b0;
        r64_carry = 1'b0;
        r64_reading = 1'b0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rd(CTRL_OFS, 8'h00);
        rd(IRQ_MASK_OFS, 8'h00);
        wr(CTRL_OFS, 8'hFF);
        rd(CTRL_OFS, 8'h18);
        rd(8'h3C, 8'h00);
        $display("test done: reset and access");

        sec_pulse();
        rd(CTRL_OFS, 8'h98);
        chk("carry_irq", {7'h0, carry_irq}, 8'h01);
        chk("irq", {7'h0, irq}, 8'h00);
        rd(IRQ_STAT_OFS, 8'h02);
        wr(IRQ_MASK_OFS, 8'h03);
        tick(1);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(IRQ_STAT_OFS, 8'h02);
        tick(1);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(CTRL_OFS, 8'h98);
        rd(CTRL_OFS, 8'h98);
        wr(CTRL_OFS, 8'h08);
        tick(1);
        chk("carry_irq", {7'h0, carry_irq}, 8'h00);
        rd(CTRL_OFS, 8'h08);
        $display("test done: carry");

        r64_pulse();
        rd(CTRL_OFS, 8'h08);
        @(posedge clock);
        r64_reading <= 1'b1;
        r64_pulse();
        r64_reading <= 1'b0;
        rd(CTRL_OFS, 8'h88);
        wr(CTRL_OFS, 8'h08);
        wr(IRQ_STAT_OFS, 8'h03);
        $display("test done: fast counter carry");

        @(posedge clock);
        cmp_count  <= 48'h0000_0000_3412;
        cmp_alarm  <= 48'h0000_0000_5512;
        cmp_enable <= 6'h03;
        tick(4);
        rd(CTRL_OFS, 8'h08);
        @(posedge clock);
        cmp_enable <= 6'h01;
        tick(3);
        rd(CTRL_OFS, 8'h09);
        chk("alarm_irq", {7'h0, alarm_irq}, 8'h01);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(CTRL_OFS, 8'h09);
        rd(CTRL_OFS, 8'h09);
        wr(CTRL_OFS, 8'h08);
        tick(1);
        chk("alarm_irq", {7'h0, alarm_irq}, 8'h00);
        rd(CTRL_OFS, 8'h08);
        wr(IRQ_STAT_OFS, 8'h03);
        cmp_enable <= 6'h00;
        $display("test done: alarm");

        standby <= 1'b1;
        wr(CTRL_OFS, 8'h10);
        sec_pulse();
        rd(CTRL_OFS, 8'h08);
        @(posedge clock);
        standby <= 1'b0;
        $display("test done: standby");

        sec_pulse();
        wr(CTRL_OFS, 8'h98);
        tick(1);
        chk("carry_irq", {7'h0, carry_irq}, 8'h01);
        @(posedge clock);
        manual_rst <= 1'b1;
        @(posedge clock);
        manual_rst <= 1'b0;
        tick(1);
        chk("carry_irq", {7'h0, carry_irq}, 8'h00);
        rd(CTRL_OFS, 8'h80);
        $display("test done: manual reset");

        wr(CTRL_OFS, 8'h18);
        @(posedge clock);
        sys_rst <= 1'b1;
        tick(2);
        chk("irq", {7'h0, irq}, 8'h00);
        @(posedge clock);
        sys_rst <= 1'b0;
        rd(CTRL_OFS, 8'h00);
        $display("test done: power-on reset");
        print_verdict();
    end
endmodule : test_rac_ctrl
`default_nettype wire
